// ==== hw/arr_core.sv ====
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module arr_core
  import arr_pkg::*;
#(
  parameter int unsigned CYC_PER_SEC_P = CYC_PER_SEC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        cpu_fail,
  input  wire logic        burnout_low_strap,
  input  wire logic        power_on,
  input  wire logic        power_dip,
  input  wire logic        noise_active,
  input  wire logic        power_off_warn,
  input  wire logic        sys_alarm,
  input  wire logic        sys_evt_valid,
  input  wire logic [7:0]  sys_evt_code,
  input  arr_cond_t        cond,
  input  wire logic [15:0] meas_ua,
  output logic      [15:0] out_ua,
  output logic             alarm_active,
  output logic             burnout_active
);

  // ----------------------------------------------------------------
  // State, submodules and shared wires
  // ----------------------------------------------------------------
  arr_main_st_t st_r;
  arr_main_st_t st_nxt;
  arr_time_t    op_time;
  arr_hist_t    hist;
  arr_asel_t    alarm_current_select;
  logic         setting_alarm_recognize;
  logic         overflow_recognize;
  logic         empty_tube_recognize;
  logic         limit_pair_recognize;
  logic         deposit_recognize;
  logic         alarm_req;
  logic         freeze;
  logic         rec_push;
  logic [7:0]   rec_code;
  logic [5:0]   pend_set;
  logic [5:0]   pend_clr;
  logic         found;

  // Operating means powered and not inside a dropout
  arr_optime #(
    .CYC_PER_SEC_P (CYC_PER_SEC_P)
  ) u_optime (
    .sys_clk (sys_clk),
    .rst     (rst),
    .run     (power_on && !power_dip),
    .op_time (op_time)
  );

  arr_history u_history (
    .sys_clk (sys_clk),
    .rst     (rst),
    .push    (rec_push),
    .code    (rec_code),
    .stamp   (op_time),
    .hist    (hist)
  );

  // Software settings decoded from the control word
  assign alarm_current_select =
    arr_asel_t'(st_r.ctrl[CTL_SEL_LSB +: 2]);
  assign setting_alarm_recognize = st_r.ctrl[CTL_SET];
  assign overflow_recognize      = st_r.ctrl[CTL_OVF];
  assign empty_tube_recognize    = st_r.ctrl[CTL_EMP];
  assign limit_pair_recognize    = st_r.ctrl[CTL_LIM];
  assign deposit_recognize       = st_r.ctrl[CTL_DEP];

  // ----------------------------------------------------------------
  // Alarm recognition
  // ----------------------------------------------------------------
  // System alarms bypass every recognition setting
  always_comb begin
    alarm_req = sys_alarm;
    if (cond.setting_err && setting_alarm_recognize)
      alarm_req = 1'b1;
    if (cond.overflow && overflow_recognize)
      alarm_req = 1'b1;
    if (cond.empty_tube && empty_tube_recognize)
      alarm_req = 1'b1;
    if (cond.deposit && deposit_recognize)
      alarm_req = 1'b1;
    // Limit alarm without a terminal or an enabled limit is inert
    if (cond.limit_hit && limit_pair_recognize && cond.limit_term
        && cond.limit_en)
      alarm_req = 1'b1;
  end

  assign freeze = power_dip || noise_active;

  // ----------------------------------------------------------------
  // Event capture for the history
  // ----------------------------------------------------------------
  // Edges are latched as pending so that events that coincide are
  // written on later cycles rather than dropped
  always_comb begin
    pend_set = 6'h00;
    pend_set[PND_DIP] = power_dip && !st_r.dip_q;
    pend_set[PND_WDT] = !noise_active && st_r.noise_q;
    pend_set[PND_OFF] = power_off_warn && !st_r.off_q;
    pend_set[PND_OVF] = cond.overflow && !st_r.cond_q.overflow
                        && overflow_recognize;
    pend_set[PND_EMP] = cond.empty_tube && !st_r.cond_q.empty_tube
                        && empty_tube_recognize;
    pend_set[PND_DEP] = cond.deposit && !st_r.cond_q.deposit
                        && deposit_recognize;
  end

  // External event first, then the lowest pending index
  always_comb begin
    rec_push = 1'b0;
    rec_code = CODE_NONE;
    pend_clr = 6'h00;
    found    = 1'b0;
    if (sys_evt_valid) begin
      rec_push = 1'b1;
      rec_code = sys_evt_code;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (!found && st_r.pend[i]) begin
          found       = 1'b1;
          rec_push    = 1'b1;
          rec_code    = PEND_CODES[i];
          pend_clr[i] = 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state: strap, failure, output mode, level, bus
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.cond_q  = cond;
    st_nxt.dip_q   = power_dip;
    st_nxt.noise_q = noise_active;
    st_nxt.off_q   = power_off_warn;
    // Set wins over clear for a pending edge in the same cycle
    st_nxt.pend    = (st_r.pend & ~pend_clr) | pend_set;

    // Burnout direction sampled once after reset, never written
    if (!st_r.strap_done) begin
      st_nxt.strap_done = 1'b1;
      st_nxt.burn_low   = burnout_low_strap;
    end
    if (cpu_fail)
      st_nxt.fail = 1'b1;

    // Output mode: failure outranks freeze, freeze outranks alarm
    if (st_nxt.fail)
      st_nxt.omode = OM_BURN;
    else if (freeze)
      st_nxt.omode = OM_FREEZE;
    else if (alarm_req)
      st_nxt.omode = OM_ALARM;
    else
      st_nxt.omode = OM_NORMAL;

    // Hold level is the output just before the alarm began
    if (st_nxt.omode == OM_ALARM && st_r.omode != OM_ALARM)
      st_nxt.hold_ua = st_r.out_ua;

    case (st_nxt.omode)
      OM_NORMAL: st_nxt.out_ua = meas_ua;
      OM_ALARM: begin
        case (alarm_current_select)
          ASEL_LOW:  st_nxt.out_ua = LVL_LOW;
          ASEL_ZERO: st_nxt.out_ua = LVL_ZERO;
          ASEL_HOLD: st_nxt.out_ua = st_nxt.hold_ua;
          // Fixed level, not clipped by any output high limit
          ASEL_HIGH: st_nxt.out_ua = LVL_HIGH;
          default:   st_nxt.out_ua = LVL_HIGH;
        endcase
      end
      // Previous value kept; resumes the cycle after the dropout ends
      OM_FREEZE: st_nxt.out_ua = st_r.out_ua;
      OM_BURN: st_nxt.out_ua = st_nxt.burn_low ? LVL_BURN_LO
                                               : LVL_BURN_HI;
      default: st_nxt.out_ua = st_r.out_ua;
    endcase

    // Bus: after a failure nothing is written and reads give zero
    st_nxt.rdata = 32'h0;
    if (!st_r.fail) begin
      if (reg_wr && reg_addr == ADR_CTRL)
        st_nxt.ctrl = reg_wdata[6:0];
      if (reg_rd) begin
        if (reg_addr == ADR_CTRL)
          st_nxt.rdata = {25'h0, st_r.ctrl};
        else if (reg_addr == ADR_STAT)
          st_nxt.rdata = {29'h0, st_r.omode == OM_FREEZE,
                          st_r.omode == OM_ALARM,
                          st_r.burn_low};
        else if (reg_addr == ADR_OPTIME)
          st_nxt.rdata = time_word(op_time);
        else if (reg_addr == ADR_OUT)
          st_nxt.rdata = {16'h0, st_r.out_ua};
        else if (reg_addr[7:4] == ADR_HCODE_BASE[7:4]
                 && reg_addr[1:0] == 2'b00)
          st_nxt.rdata = hist_word(hist[reg_addr[3:2]], 1'b0);
        else if (reg_addr[7:4] == ADR_HTIME_BASE[7:4]
                 && reg_addr[1:0] == 2'b00)
          st_nxt.rdata = hist_word(hist[reg_addr[3:2]], 1'b1);
      end
    end
  end

  // Control word takes its documented default, the rest clears
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r      <= '0;
      st_r.ctrl <= CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata      = st_r.rdata;
  assign out_ua         = st_r.out_ua;
  assign alarm_active   = (st_r.omode == OM_ALARM);
  assign burnout_active = (st_r.omode == OM_BURN);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_fail_silent: assert property (@(posedge sys_clk) disable iff (rst)
    st_r.fail |=> reg_rdata == 32'h0 && $stable(st_r.ctrl))
    else $error("bus answered after failure");
  a_burn_level: assert property (@(posedge sys_clk) disable iff (rst)
    cpu_fail ##1 st_r.strap_done |=> out_ua ==
      (st_r.burn_low ? LVL_BURN_LO : LVL_BURN_HI))
    else $error("burnout level wrong");
  a_burn_fixed: assert property (@(posedge sys_clk) disable iff (rst)
    st_r.strap_done |=> $stable(st_r.burn_low))
    else $error("burnout direction changed");

  // Levels are held against the select in force when the level was
  // loaded, so a control write in mid-alarm is not taken for a miss
  a_alarm_high: assert property (@(posedge sys_clk) disable iff (rst)
    alarm_active && $past(alarm_current_select) == ASEL_HIGH
      |-> out_ua == LVL_HIGH)
    else $error("high alarm level wrong");
  a_alarm_low: assert property (@(posedge sys_clk) disable iff (rst)
    alarm_active && $past(alarm_current_select) == ASEL_LOW
      |-> out_ua == LVL_LOW)
    else $error("low alarm level wrong");
  a_alarm_zero: assert property (@(posedge sys_clk) disable iff (rst)
    alarm_active && $past(alarm_current_select) == ASEL_ZERO
      |-> out_ua == LVL_ZERO)
    else $error("zero alarm level wrong");
  a_alarm_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !alarm_active ##1 alarm_active
      && $past(alarm_current_select) == ASEL_HOLD
      |-> out_ua == $past(out_ua))
    else $error("hold level not onset value");
  a_sys_always: assert property (@(posedge sys_clk) disable iff (rst)
    sys_alarm && !freeze && !cpu_fail && !st_r.fail |=> alarm_active)
    else $error("system alarm not raised");
  a_limit_gate: assert property (@(posedge sys_clk) disable iff (rst)
    !sys_alarm && !cond.setting_err && !cond.overflow
      && !cond.empty_tube && !cond.deposit && !cond.limit_en
      |-> !alarm_req)
    else $error("limit alarm without enabled limit");
  a_limit_term: assert property (@(posedge sys_clk) disable iff (rst)
    !sys_alarm && !cond.setting_err && !cond.overflow
      && !cond.empty_tube && !cond.deposit && !cond.limit_term
      |-> !alarm_req)
    else $error("limit alarm without terminal");
  a_limit_full: assert property (@(posedge sys_clk) disable iff (rst)
    cond.limit_hit && cond.limit_term && cond.limit_en
      && limit_pair_recognize |-> alarm_req)
    else $error("limit alarm not recognized");
  a_freeze_hold: assert property (@(posedge sys_clk) disable iff (rst)
    st_r.omode == OM_FREEZE |-> $stable(out_ua))
    else $error("output moved during dropout");
  a_noise_resume: assert property (
    @(posedge sys_clk) disable iff (rst)
    $fell(noise_active) && !power_dip && !alarm_req && !st_r.fail
      && !cpu_fail |=> st_r.omode == OM_NORMAL
      && out_ua == $past(meas_ua))
    else $error("no return to normal after noise");

  // Recording: recognized edges latch, unrecognized ones leave no trace
  a_ovf_unrec: assert property (@(posedge sys_clk) disable iff (rst)
    cond.overflow && !st_r.cond_q.overflow && !overflow_recognize
      && !st_r.pend[PND_OVF] |=> !st_r.pend[PND_OVF])
    else $error("unrecognized overflow recorded");
  a_emp_unrec: assert property (@(posedge sys_clk) disable iff (rst)
    cond.empty_tube && !st_r.cond_q.empty_tube && !empty_tube_recognize
      && !st_r.pend[PND_EMP] |=> !st_r.pend[PND_EMP])
    else $error("unrecognized empty tube recorded");
  a_dip_record: assert property (@(posedge sys_clk) disable iff (rst)
    power_dip && !st_r.dip_q |=> st_r.pend[PND_DIP])
    else $error("dropout not recorded");
  a_wdt_record: assert property (@(posedge sys_clk) disable iff (rst)
    !noise_active && st_r.noise_q |=> st_r.pend[PND_WDT])
    else $error("noise recovery not recorded");
  a_off_record: assert property (@(posedge sys_clk) disable iff (rst)
    power_off_warn && !st_r.off_q |=> st_r.pend[PND_OFF])
    else $error("power off not recorded");

  // Main scenarios
  c_alarm_hold: cover property (@(posedge sys_clk) disable iff (rst)
    alarm_active && alarm_current_select == ASEL_HOLD);
  c_burnout: cover property (@(posedge sys_clk) disable iff (rst)
    burnout_active);
  c_dip_resume: cover property (@(posedge sys_clk) disable iff (rst)
    st_r.omode == OM_FREEZE ##1 st_r.omode == OM_NORMAL);
  c_noise_resume: cover property (@(posedge sys_clk) disable iff (rst)
    $fell(noise_active) ##1 st_r.omode == OM_NORMAL);

endmodule

// ==== hw/arr_history.sv ====
`timescale 1ns/1ps
module arr_history
  import arr_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       push,
  input  wire logic [7:0] code,
  input  arr_time_t       stamp,
  output arr_hist_t       hist
);

  arr_hst_st_t st_r;
  arr_hst_st_t st_nxt;

  // ----------------------------------------------------------------
  // Recency shift register, slot 0 newest
  // ----------------------------------------------------------------
  // Oldest entry falls off the end; code zero marks an empty slot
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      for (int i = HIST_DEPTH - 1; i > 0; i--) begin
        st_nxt.slot[i] = st_r.slot[i-1];
      end
      st_nxt.slot[0].code  = code;
      st_nxt.slot[0].stamp = stamp;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign hist = st_r.slot;

  a_push_newest: assert property (@(posedge sys_clk) disable iff (rst)
    push |=> st_r.slot[0].code == $past(code)
             && st_r.slot[0].stamp == $past(stamp))
    else $error("newest slot not loaded");
  a_push_shift: assert property (@(posedge sys_clk) disable iff (rst)
    push |=> st_r.slot[3] == $past(st_r.slot[2])
             && st_r.slot[2] == $past(st_r.slot[1])
             && st_r.slot[1] == $past(st_r.slot[0]))
    else $error("history did not shift");
  c_hist_full: cover property (@(posedge sys_clk) disable iff (rst)
    st_r.slot[3].code != CODE_NONE);

endmodule

// ==== hw/arr_optime.sv ====
`timescale 1ns/1ps
module arr_optime
  import arr_pkg::*;
#(
  parameter int unsigned CYC_PER_SEC_P = CYC_PER_SEC
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic run,
  output arr_time_t op_time
);

  arr_opt_st_t st_r;
  arr_opt_st_t st_nxt;

  // ----------------------------------------------------------------
  // Prescaler, seconds, then minute/hour/day roll-over
  // ----------------------------------------------------------------
  // Halts outright when not running, so a power gap adds nothing
  always_comb begin
    st_nxt = st_r;
    if (run) begin
      if (st_r.pre == 32'(CYC_PER_SEC_P - 1)) begin
        st_nxt.pre = 32'h0;
        if (st_r.sec == SEC_LAST) begin
          st_nxt.sec = 6'h0;
          if (st_r.t.min == MIN_LAST) begin
            st_nxt.t.min = 6'h0;
            if (st_r.t.hour == HOUR_LAST) begin
              st_nxt.t.hour = 5'h0;
              st_nxt.t.day  = st_r.t.day + 16'h1;
            end else begin
              st_nxt.t.hour = st_r.t.hour + 5'h1;
            end
          end else begin
            st_nxt.t.min = st_r.t.min + 6'h1;
          end
        end else begin
          st_nxt.sec = st_r.sec + 6'h1;
        end
      end else begin
        st_nxt.pre = st_r.pre + 32'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign op_time = st_r.t;

  a_time_halt: assert property (@(posedge sys_clk) disable iff (rst)
    !run |=> $stable(st_r)) else $error("time moved while halted");
  a_time_fields: assert property (@(posedge sys_clk) disable iff (rst)
    st_r.t.min <= MIN_LAST && st_r.t.hour <= HOUR_LAST)
    else $error("minute or hour out of range");

endmodule

// ==== hw/arr_pkg.sv ====
package arr_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 125_000_000;
  localparam int unsigned TICK_S      = 1;
  localparam int unsigned CYC_PER_SEC = CLK_HZ * TICK_S;
  localparam logic [5:0]  SEC_LAST    = 6'h3B;
  localparam logic [5:0]  MIN_LAST    = 6'h3B;
  localparam logic [4:0]  HOUR_LAST   = 5'h17;
  localparam int unsigned HIST_DEPTH  = 4;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL       = 8'h00;
  localparam logic [7:0] ADR_STAT       = 8'h04;
  localparam logic [7:0] ADR_OPTIME     = 8'h08;
  localparam logic [7:0] ADR_OUT        = 8'h0C;
  localparam logic [7:0] ADR_HCODE_BASE = 8'h10;
  localparam logic [7:0] ADR_HTIME_BASE = 8'h20;
  localparam int unsigned CTL_SEL_LSB   = 0;
  localparam int unsigned CTL_SET       = 2;
  localparam int unsigned CTL_OVF       = 3;
  localparam int unsigned CTL_EMP       = 4;
  localparam int unsigned CTL_LIM       = 5;
  localparam int unsigned CTL_DEP       = 6;
  localparam logic [6:0]  CTRL_RST      = 7'h7F;
  localparam int unsigned ST_BURN_LOW   = 0;
  localparam int unsigned ST_ALARM      = 1;
  localparam int unsigned ST_FREEZE     = 2;
  localparam logic [31:0] SPACE4        = 32'h20202020;

  // ----------------------------------------------------------------
  // Alarm codes and output levels (microamps)
  // ----------------------------------------------------------------
  localparam logic [7:0]  CODE_NONE = 8'h00;
  localparam logic [7:0]  CODE_OFF  = 8'h12;
  localparam logic [7:0]  CODE_DIP  = 8'h13;
  localparam logic [7:0]  CODE_WDT  = 8'h1C;
  localparam logic [7:0]  CODE_OVF  = 8'h1E;
  localparam logic [7:0]  CODE_EMP  = 8'h1F;
  localparam logic [7:0]  CODE_DEP  = 8'h21;
  localparam int unsigned PND_DIP   = 0;
  localparam int unsigned PND_WDT   = 1;
  localparam int unsigned PND_OFF   = 2;
  localparam int unsigned PND_OVF   = 3;
  localparam int unsigned PND_EMP   = 4;
  localparam int unsigned PND_DEP   = 5;
  localparam logic [5:0][7:0] PEND_CODES =
    {CODE_DEP, CODE_EMP, CODE_OVF, CODE_OFF, CODE_WDT, CODE_DIP};
  localparam logic [15:0] LVL_LOW     = 16'h0960;
  localparam logic [15:0] LVL_ZERO    = 16'h0FA0;
  localparam logic [15:0] LVL_HIGH    = 16'h5460;
  localparam logic [15:0] LVL_BURN_HI = 16'h61A8;
  localparam logic [15:0] LVL_BURN_LO = 16'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ASEL_LOW = 2'b00, ASEL_ZERO = 2'b01, ASEL_HOLD = 2'b10, ASEL_HIGH = 2'b11
  } arr_asel_t;
  typedef enum logic [1:0] {
    OM_NORMAL = 2'b00, OM_ALARM = 2'b01, OM_FREEZE = 2'b10, OM_BURN = 2'b11
  } arr_omode_t;
  typedef struct packed {
    logic [15:0] day;
    logic [4:0]  hour;
    logic [5:0]  min;
  } arr_time_t;
  typedef struct packed {
    logic [7:0] code;
    arr_time_t  stamp;
  } arr_rec_t;
  typedef arr_rec_t [HIST_DEPTH-1:0] arr_hist_t;
  typedef struct packed {
    logic setting_err;
    logic overflow;
    logic empty_tube;
    logic deposit;
    logic limit_hit;
    logic limit_term;
    logic limit_en;
  } arr_cond_t;
  typedef struct packed {
    logic [31:0] pre;
    logic [5:0]  sec;
    arr_time_t   t;
  } arr_opt_st_t;
  typedef struct packed {
    arr_hist_t slot;
  } arr_hst_st_t;
  typedef struct packed {
    logic [6:0]  ctrl;
    logic        burn_low;
    logic        strap_done;
    logic        fail;
    arr_omode_t  omode;
    logic [15:0] hold_ua;
    logic [15:0] out_ua;
    logic [31:0] rdata;
    arr_cond_t   cond_q;
    logic        dip_q;
    logic        noise_q;
    logic        off_q;
    logic [5:0]  pend;
  } arr_main_st_t;

  // Time as one word: day, hour, minute fields
  function automatic logic [31:0] time_word(input arr_time_t t);
    return {t.day, 3'h0, t.hour, 2'h0, t.min};
  endfunction

  // Empty slot reads as space characters
  function automatic logic [31:0] hist_word(input arr_rec_t r,
                                            input logic is_time);
    if (r.code == CODE_NONE)
      return SPACE4;
    return is_time ? time_word(r.stamp) : {24'h000000, r.code};
  endfunction

endpackage

// ==== tb/arr_core_tb.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end
module arr_core_tb;
  import arr_pkg::*;
  typedef struct packed {
    logic [6:0]  ctrl;
    arr_cond_t   cond;
    logic        sys;
    logic        alm;
    logic [15:0] out;
  } arr_row_t;
  localparam logic [15:0] M = 16'h1234;
  // Ordinary cases: control word, conditions, system alarm, expected output
  localparam arr_row_t ROWS [15] = '{
    {7'h7C, 7'h00, 1'b1, 1'b1, LVL_LOW}, {7'h7D, 7'h00, 1'b1, 1'b1, LVL_ZERO},
    {7'h7E, 7'h00, 1'b1, 1'b1, M},       {7'h7F, 7'h00, 1'b1, 1'b1, LVL_HIGH},
    {7'h00, 7'h00, 1'b1, 1'b1, LVL_LOW}, {7'h00, 7'h40, 1'b0, 1'b0, M},
    {7'h04, 7'h40, 1'b0, 1'b1, LVL_LOW}, {7'h08, 7'h20, 1'b0, 1'b1, LVL_LOW},
    {7'h00, 7'h20, 1'b0, 1'b0, M},       {7'h10, 7'h10, 1'b0, 1'b1, LVL_LOW},
    {7'h40, 7'h08, 1'b0, 1'b1, LVL_LOW}, {7'h20, 7'h07, 1'b0, 1'b1, LVL_LOW},
    {7'h20, 7'h06, 1'b0, 1'b0, M},       {7'h20, 7'h05, 1'b0, 1'b0, M},
    {7'h00, 7'h07, 1'b0, 1'b0, M}};
  logic        sys_clk, rst, reg_wr, reg_rd, cpu_fail, burnout_low_strap;
  logic        power_on, power_dip, noise_active, power_off_warn;
  logic        sys_alarm, sys_evt_valid, alarm_active, burnout_active;
  logic [7:0]  reg_addr, sys_evt_code;
  logic [31:0] reg_wdata, reg_rdata, t0, t1, d;
  logic [15:0] meas_ua, out_ua;
  arr_cond_t   cond;
  int          err_count, cmp_count, cyc_cnt;

  arr_core #(.CYC_PER_SEC_P(4)) arr_core_inst (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu_fail(cpu_fail),
    .burnout_low_strap(burnout_low_strap), .power_on(power_on),
    .power_dip(power_dip), .noise_active(noise_active),
    .power_off_warn(power_off_warn), .sys_alarm(sys_alarm),
    .sys_evt_valid(sys_evt_valid), .sys_evt_code(sys_evt_code),
    .cond(cond), .meas_ua(meas_ua), .out_ua(out_ua),
    .alarm_active(alarm_active), .burnout_active(burnout_active));

  // ------------------------------------------------------------
  // Clock, timeout and bus tasks
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Ceiling well above the roughly 1200 cycles the sequence needs
  always @(posedge sys_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    // Taken at the edge that closes the data cycle, before it clears
    @(posedge sys_clk);
    v = reg_rdata;
  endtask
  task automatic pulse_cond(input arr_cond_t c);
    @(posedge sys_clk) cond <= c;
    cyc(3);
    cond <= '0;
    cyc(3);
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    cyc(16);
    rst <= 1'b0;
    cyc(2);
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {rst, reg_wr, reg_rd, cpu_fail, burnout_low_strap, power_on} = 6'h20;
    {power_dip, noise_active, power_off_warn, sys_alarm} = 4'h0;
    {sys_evt_valid, sys_evt_code, reg_addr, reg_wdata} = '0;
    {cond, err_count, cmp_count, cyc_cnt} = '0;
    meas_ua = M;
    do_reset();
    rd(ADR_CTRL, d); `CHK(d, {25'h0, CTRL_RST})
    rd(ADR_HCODE_BASE, d); `CHK(d, SPACE4)
    rd(8'hFC, d); `CHK(d, 32'h0)
    // Power off freezes time, power on advances it by whole minutes
    rd(ADR_OPTIME, t0); cyc(480); rd(ADR_OPTIME, t1);
    `CHK(t1, t0)
    @(posedge sys_clk) power_on <= 1'b1;
    cyc(480);
    power_on <= 1'b0;
    rd(ADR_OPTIME, t1);
    `CHK(t1[31:8], 24'h0)
    `CHK((t1[5:0] - t0[5:0]) inside {6'h1, 6'h2}, 1'b1)
    foreach (ROWS[i]) begin
      wr(ADR_CTRL, {25'h0, ROWS[i].ctrl});
      cond <= ROWS[i].cond; sys_alarm <= ROWS[i].sys;
      cyc(3);
      `CHK({alarm_active, out_ua}, {ROWS[i].alm, ROWS[i].out})
      cond <= '0; sys_alarm <= 1'b0;
      cyc(3);
    end
    // History: empty tube not recognized, time frozen for exact stamps
    wr(ADR_CTRL, 32'h68);
    @(posedge sys_clk) begin sys_evt_valid <= 1'b1; sys_evt_code <= 8'h0B; end
    @(posedge sys_clk) sys_evt_valid <= 1'b0;
    pulse_cond(7'h20);
    rd(ADR_HCODE_BASE, d); `CHK(d, 32'h1E)
    rd(ADR_HCODE_BASE + 8'h04, d); `CHK(d, 32'h0B)
    rd(ADR_HTIME_BASE, d); `CHK(d, t1)
    pulse_cond(7'h08);
    pulse_cond(7'h10);
    // Dropout holds output, then resumes at once
    @(posedge sys_clk) power_dip <= 1'b1;
    cyc(2); meas_ua <= 16'h0ABC; cyc(3);
    `CHK(out_ua, M)
    power_dip <= 1'b0; cyc(2);
    `CHK(out_ua, 16'h0ABC)
    noise_active <= 1'b1; cyc(3); meas_ua <= M; noise_active <= 1'b0; cyc(2);
    `CHK(out_ua, M)
    power_off_warn <= 1'b1; cyc(3); power_off_warn <= 1'b0; cyc(2);
    rd(ADR_HCODE_BASE, d); `CHK(d, {24'h0, CODE_OFF})
    rd(ADR_HCODE_BASE + 8'h04, d); `CHK(d, {24'h0, CODE_WDT})
    rd(ADR_HCODE_BASE + 8'h08, d); `CHK(d, {24'h0, CODE_DIP})
    rd(ADR_HCODE_BASE + 8'h0C, d); `CHK(d, {24'h0, CODE_DEP})
    rd(ADR_HTIME_BASE + 8'h0C, d); `CHK(d, t1)
    // Failure: burnout level, bus silent afterwards
    @(posedge sys_clk) cpu_fail <= 1'b1;
    cyc(3);
    `CHK({burnout_active, out_ua}, {1'b1, LVL_BURN_HI})
    wr(ADR_CTRL, 32'h0); rd(ADR_CTRL, d); `CHK(d, 32'h0)
    cpu_fail <= 1'b0; burnout_low_strap <= 1'b1;
    do_reset();
    rd(ADR_STAT, d); `CHK(d[ST_BURN_LOW], 1'b1)
    cpu_fail <= 1'b1; cyc(3);
    `CHK({burnout_active, out_ua}, {1'b1, LVL_BURN_LO})
    report_and_stop();
  end
endmodule
